// ==== rtl/pmux_pin_cell.sv ====
// One port pin: output select, enable, pull-up and read-back path.
// Assumes the pad ring turns out, oe and pu into the pin's real level.
`timescale 1ns/1ps
`default_nettype none
module pmux_pin_cell (
	input wire logic dir_in,
	input wire logic latch,
	input wire logic alt_en,
	input wire logic alt_val,
	input wire logic pu_en,
	input wire logic analog,
	input wire logic force_drive,
	input wire logic hiz,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe,
	output logic pad_pu,
	output logic rd_val,
	output logic dig_in
);
	// ----------------------------------------
	// Output path
	// ----------------------------------------
	// Alternate signal replaces the latch [R21] [R14]
	assign pad_out = alt_en ? alt_val : latch;
	// Drive as output or when forced, never as analog input or while hiz [R18] [R05] [R06]
	assign pad_oe = (force_drive | ~dir_in) & ~analog & ~hiz;
	// Pull-up only on a digital input; analog drops it [R19] [R09]
	assign pad_pu = pu_en & dir_in & ~analog & ~force_drive;
	// ----------------------------------------
	// Input path
	// ----------------------------------------
	// Output pins read what they drive [R20]
	assign rd_val = analog ? 1'b0 : (dir_in ? pad_in : pad_out);
	// Digital level for shared inputs; blocked while analog [R08]
	assign dig_in = analog ? 1'b0 : pad_in;
endmodule
`default_nettype wire

// ==== rtl/pmux_pkg.sv ====
// Types shared by the pin mux files.
// Assumes the register header supplies every number.
package pmux_pkg;
	// One port byte
	typedef logic [7:0] pmux_byte_t;
	// Target of a single-bit set or clear, in field order
	typedef enum logic [1:0] {
		PMUX_TGT_PA_DATA,
		PMUX_TGT_PA_DIR,
		PMUX_TGT_PB_DATA,
		PMUX_TGT_PB_DIR
	} pmux_tgt_t;
endpackage

// ==== rtl/pmux_regs.svh ====
// Register offsets, field positions, reset values and counts of the pin mux.
// Assumes a 32-bit APB slave that decodes the low 12 address bits.
`ifndef PMUX_REGS_SVH
`define PMUX_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PMUX_OFF_PA_DATA 12'h000
`define PMUX_OFF_PA_DIR 12'h004
`define PMUX_OFF_PA_PU 12'h008
`define PMUX_OFF_PA_WAKE 12'h00c
`define PMUX_OFF_PB_DATA 12'h010
`define PMUX_OFF_PB_DIR 12'h014
`define PMUX_OFF_PB_PU 12'h018
`define PMUX_OFF_MISC_A 12'h01c
`define PMUX_OFF_LCD 12'h020
`define PMUX_OFF_CONV 12'h024
`define PMUX_OFF_BITOP 12'h028

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMUX_RST_ONES 8'hff
`define PMUX_RST_ZERO 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMUX_MISC_REMAP 0
`define PMUX_MISC_FDO_EN 1
`define PMUX_MISC_PWM0_EN 2
`define PMUX_MISC_PWM1_EN 3
`define PMUX_LCD_ON 7
`define PMUX_BOP_SET 3
`define PMUX_BOP_TGT_LSB 4

// ----------------------------------------
// Pin positions of shared functions
// ----------------------------------------
`define PMUX_PA_IRQ 3
`define PMUX_PA_EV0 2
`define PMUX_PA_FDO 1
`define PMUX_PA_EV1 0
`define PMUX_PA_PWM0 4
`define PMUX_PA_PWM1 5
`define PMUX_PB_IRQ 5
`define PMUX_PB_EV0 4
`define PMUX_PB_FDO 3

// ----------------------------------------
// Timer mode codes seen on the mode inputs
// ----------------------------------------
`define PMUX_TMODE_EVENT 2'h1
`define PMUX_TMODE_CAPTURE 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMUX_LCD_SLOT_CYC 1000

`endif

// ==== rtl/pmux_top.sv ====
// Pin sharing and remap logic for ports A and B, with its APB registers.
// Assumes pins are already synchronous to pclk and pready is never waited.
//
// Contract
// R01: Software sets irq pin as input first.
// R02: Irq pin keeps its normal port read.
// R03: Event pin feeds timer only in event/capture.
// R04: Event pin is input and still readable.
// R05: Divider output needs output direction.
// R06: PWM drives only when pin is output.
// R07: Port B low four pins drive LCD commons.
// R08: Per-pin analog select switches pin to converter.
// R09: Analog pin loses its pull-up.
// R10: One bit moves irq, event0, divider together.
// R11: Remap clears at reset; 0 port A, 1 port B.
// R12: Remap and pin sharing decode independently.
// R13: Reset sets all data and direction ones.
// R14: Unwritten latch drives high on output.
// R15: Bit set/clear reads port, writes byte.
// R16: Falling enabled port A pin wakes sleeper.
// R17: Wake enable exists per port A pin.
// R18: Direction zero output, one input.
// R19: Pull-up only when set and input.
// R20: Output pin reads its driven state.
// R21: Enabled alternate output replaces latch.
`timescale 1ns/1ps
`default_nettype none
`include "pmux_regs.svh"
module pmux_top #(
	parameter int PA_W = 8,
	parameter int PB_W = 6,
	parameter int AN_N = 8,
	parameter int LCD_SLOT_CYC = `PMUX_LCD_SLOT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PA_W-1:0] pa_in,
	output logic [PA_W-1:0] pa_out,
	output logic [PA_W-1:0] pa_oe,
	output logic [PA_W-1:0] pa_pu,
	input wire logic [PB_W-1:0] pb_in,
	output logic [PB_W-1:0] pb_out,
	output logic [PB_W-1:0] pb_oe,
	output logic [PB_W-1:0] pb_pu,
	output logic [3:0] pb_lcd_bias,
	output logic [AN_N-1:0] an_sel,
	output logic ext_irq_in,
	output logic event_in0_pin,
	output logic event_in1_pin,
	input wire logic [1:0] tmr0_mode,
	input wire logic [1:0] tmr1_mode,
	input wire logic freq_div_out,
	input wire logic pwm0_in,
	input wire logic pwm1_in,
	input wire logic sleep_mode,
	output logic wake_req
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Offset match on an aligned word
	function automatic logic pmux_hit(input logic [11:0] a,
		input logic [11:0] off);
		pmux_hit = (a[11:2] == off[11:2]);
	endfunction

	// Set or clear one bit of a whole byte
	function automatic pmux_pkg::pmux_byte_t pmux_bitop(
		input pmux_pkg::pmux_byte_t cur, input logic [2:0] idx,
		input logic set);
		pmux_pkg::pmux_byte_t m;
		m = 8'(8'h01 << idx);
		pmux_bitop = set ? (cur | m) : (cur & ~m);
	endfunction

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [PA_W-1:0] pa_data_q; // Port A output latch
	logic [PA_W-1:0] pa_dir_q; // Port A direction, 1 input
	logic [PA_W-1:0] pa_pu_q; // Port A pull-up enables
	logic [PA_W-1:0] pa_wake_q; // Port A wake enables
	logic [PB_W-1:0] pb_data_q; // Port B output latch
	logic [PB_W-1:0] pb_dir_q; // Port B direction
	logic [PB_W-1:0] pb_pu_q; // Port B pull-up enables
	logic [7:0] misc_a_q; // Remap and function enables
	logic [7:0] lcd_common_ctrl_q; // LCD common control
	logic [AN_N-1:0] analog_pin_cfg_q; // Converter pin selects
	logic [31:0] prdata_q; // Read data, loaded in setup
	logic [PA_W-1:0] pa_prev_q; // Port A level one cycle ago
	logic wake_q; // Wake pulse
	logic [15:0] lcd_div_q; // LCD slot timer
	logic [2:0] lcd_slot_q; // LCD scan slot

	// ----------------------------------------
	// Combinational nets
	// ----------------------------------------
	logic [PA_W-1:0] pa_rd; // Port A read value
	logic [PB_W-1:0] pb_rd; // Port B read value
	logic [PA_W-1:0] pa_dig; // Port A digital input level
	logic [PB_W-1:0] pb_dig; // Port B digital input level
	logic [PA_W-1:0] pa_alt_en;
	logic [PA_W-1:0] pa_alt_val;
	logic [PA_W-1:0] pa_an;
	logic [PB_W-1:0] pb_alt_en;
	logic [PB_W-1:0] pb_alt_val;
	logic [PB_W-1:0] pb_force;
	logic [PB_W-1:0] pb_hiz;
	logic wr_acc; // Write in access phase
	logic mapped; // Address hits a register
	logic remap; // Remap select bit
	logic lcd_on; // LCD commons running
	logic [2:0] bop_idx;
	logic bop_set;
	pmux_pkg::pmux_tgt_t bop_tgt;
	pmux_pkg::pmux_byte_t pa_rd_b;
	pmux_pkg::pmux_byte_t pb_rd_b;

	assign remap = misc_a_q[`PMUX_MISC_REMAP];
	assign lcd_on = lcd_common_ctrl_q[`PMUX_LCD_ON];
	assign wr_acc = psel & penable & pwrite;
	assign bop_idx = pwdata[2:0];
	assign bop_set = pwdata[`PMUX_BOP_SET];
	assign bop_tgt = pmux_pkg::pmux_tgt_t'(pwdata[5:4]);
	assign pa_rd_b = 8'(pa_rd);
	assign pb_rd_b = 8'(pb_rd);

	// ----------------------------------------
	// APB handshake
	// ----------------------------------------
	// Zero-wait slave; data is ready from the setup edge
	assign pready = 1'b1;
	assign mapped = pmux_hit(paddr, `PMUX_OFF_PA_DATA)
		| pmux_hit(paddr, `PMUX_OFF_PA_DIR)
		| pmux_hit(paddr, `PMUX_OFF_PA_PU)
		| pmux_hit(paddr, `PMUX_OFF_PA_WAKE)
		| pmux_hit(paddr, `PMUX_OFF_PB_DATA)
		| pmux_hit(paddr, `PMUX_OFF_PB_DIR)
		| pmux_hit(paddr, `PMUX_OFF_PB_PU)
		| pmux_hit(paddr, `PMUX_OFF_MISC_A)
		| pmux_hit(paddr, `PMUX_OFF_LCD)
		| pmux_hit(paddr, `PMUX_OFF_CONV)
		| pmux_hit(paddr, `PMUX_OFF_BITOP);
	// Unmapped addresses answer with an error, writes dropped
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_q;

	// Read mux sampled at the setup edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (psel && !penable) begin
			// Ports read through the pins, as a plain port read
			if (pmux_hit(paddr, `PMUX_OFF_PA_DATA)) begin
				prdata_q <= 32'(pa_rd); // [R02] [R04] [R20]
			end else if (pmux_hit(paddr, `PMUX_OFF_PA_DIR)) begin
				prdata_q <= 32'(pa_dir_q);
			end else if (pmux_hit(paddr, `PMUX_OFF_PA_PU)) begin
				prdata_q <= 32'(pa_pu_q);
			end else if (pmux_hit(paddr, `PMUX_OFF_PA_WAKE)) begin
				prdata_q <= 32'(pa_wake_q);
			end else if (pmux_hit(paddr, `PMUX_OFF_PB_DATA)) begin
				prdata_q <= 32'(pb_rd);
			end else if (pmux_hit(paddr, `PMUX_OFF_PB_DIR)) begin
				prdata_q <= 32'(pb_dir_q);
			end else if (pmux_hit(paddr, `PMUX_OFF_PB_PU)) begin
				prdata_q <= 32'(pb_pu_q);
			end else if (pmux_hit(paddr, `PMUX_OFF_MISC_A)) begin
				prdata_q <= 32'(misc_a_q);
			end else if (pmux_hit(paddr, `PMUX_OFF_LCD)) begin
				prdata_q <= 32'(lcd_common_ctrl_q);
			end else if (pmux_hit(paddr, `PMUX_OFF_CONV)) begin
				prdata_q <= 32'(analog_pin_cfg_q);
			end else begin
				// Bit-op register and holes read as zero
				prdata_q <= 32'h0;
			end
		end
	end

	// ----------------------------------------
	// Port A registers
	// ----------------------------------------
	// Latch: byte write or read-modify-write bit op
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_data_q <= PA_W'(`PMUX_RST_ONES); // [R13] [R14]
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_PA_DATA)) begin
			pa_data_q <= pwdata[PA_W-1:0];
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_BITOP)
			&& bop_tgt == pmux_pkg::PMUX_TGT_PA_DATA) begin
			// Whole port read back, so input pins copy their level
			pa_data_q <= PA_W'(pmux_bitop(pa_rd_b, bop_idx, bop_set)); // [R15]
		end
	end

	// Direction: resets to all inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_dir_q <= PA_W'(`PMUX_RST_ONES); // [R13]
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_PA_DIR)) begin
			pa_dir_q <= pwdata[PA_W-1:0];
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_BITOP)
			&& bop_tgt == pmux_pkg::PMUX_TGT_PA_DIR) begin
			pa_dir_q <= PA_W'(pmux_bitop(8'(pa_dir_q), bop_idx,
				bop_set)); // [R15]
		end
	end

	// Pull-up and wake enables, one bit per pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_pu_q <= PA_W'(`PMUX_RST_ZERO);
			pa_wake_q <= PA_W'(`PMUX_RST_ZERO);
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_PA_PU)) begin
			pa_pu_q <= pwdata[PA_W-1:0];
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_PA_WAKE)) begin
			pa_wake_q <= pwdata[PA_W-1:0]; // [R17]
		end
	end

	// ----------------------------------------
	// Port B registers
	// ----------------------------------------
	// Latch and direction; bit op index above width leaves direction alone, latch reloads from port read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pb_data_q <= PB_W'(`PMUX_RST_ONES); // [R13] [R14]
			pb_dir_q <= PB_W'(`PMUX_RST_ONES);
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_PB_DATA)) begin
			pb_data_q <= pwdata[PB_W-1:0];
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_PB_DIR)) begin
			pb_dir_q <= pwdata[PB_W-1:0];
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_BITOP)) begin
			if (bop_tgt == pmux_pkg::PMUX_TGT_PB_DATA) begin
				pb_data_q <= PB_W'(pmux_bitop(pb_rd_b, bop_idx, bop_set)); // [R15]
			end else if (bop_tgt == pmux_pkg::PMUX_TGT_PB_DIR) begin
				pb_dir_q <= PB_W'(pmux_bitop(8'(pb_dir_q), bop_idx,
					bop_set)); // [R15]
			end
		end
	end

	// Port B pull-ups
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pb_pu_q <= PB_W'(`PMUX_RST_ZERO);
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_PB_PU)) begin
			pb_pu_q <= pwdata[PB_W-1:0];
		end
	end

	// ----------------------------------------
	// Function control registers
	// ----------------------------------------
	// Remap, enables, LCD and converter pin selects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc_a_q <= `PMUX_RST_ZERO; // [R11]
			lcd_common_ctrl_q <= `PMUX_RST_ZERO;
			analog_pin_cfg_q <= AN_N'(`PMUX_RST_ZERO);
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_MISC_A)) begin
			misc_a_q <= pwdata[7:0]; // [R10]
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_LCD)) begin
			lcd_common_ctrl_q <= pwdata[7:0]; // [R07]
		end else if (wr_acc && pmux_hit(paddr, `PMUX_OFF_CONV)) begin
			analog_pin_cfg_q <= pwdata[AN_N-1:0]; // [R08]
		end
	end

	// ----------------------------------------
	// LCD common scan
	// ----------------------------------------
	// Eight slots: each common low then high, the rest at mid bias
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcd_div_q <= 16'h0;
			lcd_slot_q <= 3'h0;
		end else if (!lcd_on) begin
			// Held still while off to save toggling
			lcd_div_q <= 16'h0;
			lcd_slot_q <= 3'h0;
		end else if (lcd_div_q == 16'(LCD_SLOT_CYC - 1)) begin
			lcd_div_q <= 16'h0;
			lcd_slot_q <= lcd_slot_q + 3'h1;
		end else begin
			lcd_div_q <= lcd_div_q + 16'h1;
		end
	end

	// ----------------------------------------
	// Alternate function select
	// ----------------------------------------
	// Remap touches only pin choice, sharing only enables [R12]
	always_comb begin
		pa_alt_en = '0;
		pa_alt_val = '0;
		pb_alt_en = '0;
		pb_alt_val = '0;
		pb_force = '0;
		pb_hiz = '0;
		// Divider output follows the remap bit [R10] [R11] [R05]
		if (misc_a_q[`PMUX_MISC_FDO_EN]) begin
			if (remap) begin
				pb_alt_en[`PMUX_PB_FDO] = 1'b1;
				pb_alt_val[`PMUX_PB_FDO] = freq_div_out;
			end else begin
				pa_alt_en[`PMUX_PA_FDO] = 1'b1;
				pa_alt_val[`PMUX_PA_FDO] = freq_div_out;
			end
		end
		// PWM outputs on fixed pins [R06] [R21]
		pa_alt_en[`PMUX_PA_PWM0] = misc_a_q[`PMUX_MISC_PWM0_EN];
		pa_alt_val[`PMUX_PA_PWM0] = pwm0_in;
		pa_alt_en[`PMUX_PA_PWM1] = misc_a_q[`PMUX_MISC_PWM1_EN];
		pa_alt_val[`PMUX_PA_PWM1] = pwm1_in;
		// LCD commons override port B 0..3 [R07]
		for (int k = 0; k < 4; k++) begin
			if (lcd_on && lcd_common_ctrl_q[k]) begin
				pb_force[k] = 1'b1;
				pb_alt_en[k] = 1'b1;
				pb_alt_val[k] = lcd_slot_q[2];
				pb_hiz[k] = (lcd_slot_q[1:0] != 2'(k));
			end
		end
	end
	// Mid level: pin released, bias network on
	assign pb_lcd_bias = pb_hiz[3:0];

	// ----------------------------------------
	// Pin cells
	// ----------------------------------------
	assign pa_an = PA_W'(analog_pin_cfg_q);
	assign an_sel = analog_pin_cfg_q; // [R08] [R09]

	genvar gi;
	generate
		for (gi = 0; gi < PA_W; gi++) begin : g_pa
			pmux_pin_cell u_cell (
				.dir_in(pa_dir_q[gi]),
				.latch(pa_data_q[gi]),
				.alt_en(pa_alt_en[gi]),
				.alt_val(pa_alt_val[gi]),
				.pu_en(pa_pu_q[gi]),
				.analog(pa_an[gi]),
				.force_drive(1'b0),
				.hiz(1'b0),
				.pad_in(pa_in[gi]),
				.pad_out(pa_out[gi]),
				.pad_oe(pa_oe[gi]),
				.pad_pu(pa_pu[gi]),
				.rd_val(pa_rd[gi]),
				.dig_in(pa_dig[gi])
			);
		end
		for (gi = 0; gi < PB_W; gi++) begin : g_pb
			pmux_pin_cell u_cell (
				.dir_in(pb_dir_q[gi]),
				.latch(pb_data_q[gi]),
				.alt_en(pb_alt_en[gi]),
				.alt_val(pb_alt_val[gi]),
				.pu_en(pb_pu_q[gi]),
				.analog(1'b0),
				.force_drive(pb_force[gi]),
				.hiz(pb_hiz[gi]),
				.pad_in(pb_in[gi]),
				.pad_out(pb_out[gi]),
				.pad_oe(pb_oe[gi]),
				.pad_pu(pb_pu[gi]),
				.rd_val(pb_rd[gi]),
				.dig_in(pb_dig[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Shared inputs
	// ----------------------------------------
	// Interrupt level taken from the pin, port read untouched
	assign ext_irq_in = remap ? pb_dig[`PMUX_PB_IRQ]
		: pa_dig[`PMUX_PA_IRQ]; // [R02] [R10] [R11] [R01]
	// Event inputs reach a timer only in event or capture mode
	assign event_in0_pin = ((tmr0_mode == `PMUX_TMODE_EVENT)
		|| (tmr0_mode == `PMUX_TMODE_CAPTURE))
		&& (remap ? pb_dig[`PMUX_PB_EV0] : pa_dig[`PMUX_PA_EV0]); // [R03] [R04]
	assign event_in1_pin = ((tmr1_mode == `PMUX_TMODE_EVENT)
		|| (tmr1_mode == `PMUX_TMODE_CAPTURE))
		&& pa_dig[`PMUX_PA_EV1]; // [R03] [R04]

	// ----------------------------------------
	// Port A wake-up
	// ----------------------------------------
	// Previous level for falling-edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_prev_q <= '0;
		end else begin
			pa_prev_q <= pa_in;
		end
	end

	// One-cycle wake pulse on any enabled high-to-low edge while sleep_mode is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= sleep_mode && |(pa_wake_q & pa_prev_q & ~pa_in); // [R16] [R17]
		end
	end
	assign wake_req = wake_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_reset_ones;
		@(posedge pclk) disable iff (!presetn)
		!$past(presetn) |-> (&pa_data_q && &pa_dir_q && &pb_dir_q
			&& !remap);
	endproperty
	a_reset_ones: assert property (p_reset_ones) // [R13] [R11]
		else $error("ports not all ones after reset");

	property p_remap_irq;
		@(posedge pclk) disable iff (!presetn)
		(!an_sel[`PMUX_PA_IRQ]) |-> (ext_irq_in == (remap
			? pb_in[`PMUX_PB_IRQ] : pa_in[`PMUX_PA_IRQ]));
	endproperty
	a_remap_irq: assert property (p_remap_irq) // [R10]
		else $error("irq pin routing wrong");

	property p_event_mode;
		@(posedge pclk) disable iff (!presetn)
		(tmr0_mode != `PMUX_TMODE_EVENT
			&& tmr0_mode != `PMUX_TMODE_CAPTURE) |-> !event_in0_pin;
	endproperty
	a_event_mode: assert property (p_event_mode) // [R03]
		else $error("event input passed in wrong mode");

	property p_pwm_input;
		@(posedge pclk) disable iff (!presetn)
		(misc_a_q[`PMUX_MISC_PWM0_EN] && pa_dir_q[`PMUX_PA_PWM0])
			|-> !pa_oe[`PMUX_PA_PWM0];
	endproperty
	a_pwm_input: assert property (p_pwm_input) // [R06]
		else $error("pwm drove an input pin");

	property p_pwm_drive;
		@(posedge pclk) disable iff (!presetn)
		(misc_a_q[`PMUX_MISC_PWM0_EN] && !pa_dir_q[`PMUX_PA_PWM0]
			&& !pa_an[`PMUX_PA_PWM0]) |-> (pa_oe[`PMUX_PA_PWM0]
			&& pa_out[`PMUX_PA_PWM0] == pwm0_in);
	endproperty
	a_pwm_drive: assert property (p_pwm_drive) // [R21]
		else $error("pwm not on output pin");

	property p_fdo_dir;
		@(posedge pclk) disable iff (!presetn)
		(!remap && pa_dir_q[`PMUX_PA_FDO]) |-> !pa_oe[`PMUX_PA_FDO];
	endproperty
	a_fdo_dir: assert property (p_fdo_dir) // [R05]
		else $error("divider drove an input pin");

	property p_analog_pu;
		@(posedge pclk) disable iff (!presetn)
		an_sel[0] |-> (!pa_pu[0] && !pa_oe[0]);
	endproperty
	a_analog_pu: assert property (p_analog_pu) // [R09]
		else $error("analog pin kept pull-up");

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
		(sleep_mode && pa_wake_q[0] && $past(pa_in[0]) && !pa_in[0]
			&& $past(presetn)) |=> wake_req;
	endproperty
	a_wake: assert property (p_wake) // [R16]
		else $error("missed port A wake edge");

	property p_bitop;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && pmux_hit(paddr, `PMUX_OFF_BITOP) && pwdata[5:0] == 6'h08)
			|=> (pa_data_q[0] && pa_data_q[PA_W-1:1] == $past(pa_rd[PA_W-1:1]));
	endproperty
	a_bitop: assert property (p_bitop) // [R15]
		else $error("bit set lost port byte");

	property p_read_out;
		@(posedge pclk) disable iff (!presetn)
		(!pa_dir_q[7] && !pa_an[7]) |-> (pa_rd[7] == pa_out[7]);
	endproperty
	a_read_out: assert property (p_read_out) // [R20]
		else $error("output pin read wrong");

	property p_lcd;
		@(posedge pclk) disable iff (!presetn)
		(lcd_on && lcd_common_ctrl_q[0]) |-> (pb_oe[0] ^ pb_lcd_bias[0]);
	endproperty
	a_lcd: assert property (p_lcd) // [R07]
		else $error("lcd common neither driven nor biased");

	c_bitop: cover property (@(posedge pclk) disable iff (!presetn)
		wr_acc && pmux_hit(paddr, `PMUX_OFF_BITOP));
	c_wake: cover property (@(posedge pclk) disable iff (!presetn)
		wake_req);
	c_remap: cover property (@(posedge pclk) disable iff (!presetn)
		remap && event_in0_pin);
endmodule
`default_nettype wire

// ==== sim/pmux_pad_model.sv ====
// Pad model: resolves pin levels from the mux drive and outside drivers.
// Assumes the bench drives ext_en and ext_val at clock edges.
`timescale 1ns/1ps
`default_nettype none
module pmux_pad_model #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic [W-1:0] drv,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] pu,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] lvl
);
	// Registered, as the pins reach the mux synchronised
	initial lvl = '0;
	// Floating pins flip each cycle, so no stale level reads as valid
	always @(posedge clk) begin
		for (int i = 0; i < W; i++) begin
			lvl[i] <= oe[i] ? drv[i] : ext_en[i] ? ext_val[i] :
				pu[i] ? 1'b1 : ~lvl[i];
		end
	end
endmodule
`default_nettype wire

// ==== sim/tb_port_pin_function_mux.sv ====
// Testbench for the pin mux: APB scenarios against pad models.
// Assumes the register header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pmux_regs.svh"
module tb_port_pin_function_mux;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] pa_in, pa_out, pa_oe, pa_pu, pa_ee, pa_ev, an_sel;
	logic [5:0] pb_in, pb_out, pb_oe, pb_pu, pb_ee, pb_ev;
	logic [3:0] lcd;
	logic irq, ev0, ev1, fdo, sleep_mode, wake_req, pwm0;
	logic [1:0] tm0, tm1; // Timer modes seen by the event gates
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int k;
	pmux_top #(.LCD_SLOT_CYC(4)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
		.pa_pu(pa_pu), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
		.pb_pu(pb_pu), .pb_lcd_bias(lcd), .an_sel(an_sel),
		.ext_irq_in(irq), .event_in0_pin(ev0), .event_in1_pin(ev1),
		.tmr0_mode(tm0), .tmr1_mode(tm1), .freq_div_out(fdo),
		.pwm0_in(pwm0), .pwm1_in(1'b0), .sleep_mode(sleep_mode),
		.wake_req(wake_req));
	pmux_pad_model #(.W(8)) u_pa (.clk(pclk), .drv(pa_out), .oe(pa_oe),
		.pu(pa_pu), .ext_en(pa_ee), .ext_val(pa_ev), .lvl(pa_in));
	pmux_pad_model #(.W(6)) u_pb (.clk(pclk), .drv(pb_out), .oe(pb_oe),
		.pu(pb_pu), .ext_en(pb_ee), .ext_val(pb_ev), .lvl(pb_in));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Hang guard, far above the run length
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Request held until pready seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Outputs looked at mid-cycle, once edge updates have landed
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic wakes(input logic [7:0] v);
		@(posedge pclk);
		pa_ev <= v;
		k = 0;
		repeat (4) begin
			@(negedge pclk);
			if (wake_req === 1'b1)
				k++;
		end
		// Back on a rising edge, so callers drive inputs there
		@(posedge pclk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, fdo, sleep_mode, tm0, tm1,
			pwm0} = '0;
		pa_ee = 8'hff;
		pa_ev = 8'hff;
		pb_ee = 6'h3f;
		pb_ev = 6'h00;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// Defaults after reset
		apb(1'b0, `PMUX_OFF_PA_DIR, 32'h0);
		chk(rd, 32'hff);
		apb(1'b0, `PMUX_OFF_PB_DIR, 32'h0);
		chk(rd, 32'h3f);
		apb(1'b0, `PMUX_OFF_MISC_A, 32'h0);
		chk(rd, 32'h0);
		chk(pa_oe, 8'h00);
		// Wake only from the enabled pin; irq pin left input
		apb(1'b1, `PMUX_OFF_PA_WAKE, 32'h08);
		sleep_mode <= 1'b1;
		wakes(8'hfb);
		chk(k, 0);
		wakes(8'hf3);
		chk(k, 1);
		sleep_mode <= 1'b0;
		chk(irq, 1'b0);
		apb(1'b0, `PMUX_OFF_PA_DATA, 32'h0);
		chk(rd, 32'hf3);
		// Single-bit clear of PA dir bit 7
		apb(1'b1, `PMUX_OFF_BITOP, 32'h17);
		apb(1'b0, `PMUX_OFF_PA_DIR, 32'h0);
		chk(rd, 32'h7f);
		chk(pa_oe, 8'h80);
		// Outputs from the reset latch, then divider output
		apb(1'b1, `PMUX_OFF_PA_DIR, 32'h0);
		settle(0);
		chk(pa_out, 8'hff);
		apb(1'b0, `PMUX_OFF_PA_DATA, 32'h0);
		chk(rd, 32'hff);
		apb(1'b1, `PMUX_OFF_MISC_A, 32'h2);
		settle(0);
		chk(pa_out, 8'hfd);
		apb(1'b1, `PMUX_OFF_PA_DIR, 32'h2);
		settle(0);
		chk(pa_oe, 8'hfd);
		// Remap moves divider and irq to port B
		apb(1'b1, `PMUX_OFF_MISC_A, 32'h3);
		apb(1'b1, `PMUX_OFF_PB_DIR, 32'h37);
		pb_ev <= 6'h20;
		settle(2);
		chk(pb_out[3], 1'b0);
		chk(pb_oe, 6'h08);
		chk(irq, 1'b1);
		// Event inputs pass only in counting or capture modes
		@(posedge pclk);
		tm0 <= 2'h1;
		tm1 <= 2'h3;
		fdo <= 1'b1;
		pb_ev <= 6'h30;
		settle(1);
		chk({ev0, ev1}, 2'h3);
		apb(1'b0, `PMUX_OFF_PB_DATA, 32'h0);
		chk(rd, 32'h38);
		tm0 <= 2'h2;
		tm1 <= 2'h0;
		settle(0);
		chk({ev0, ev1}, 2'h0);
		// Pull-ups only on digital inputs
		pa_ee <= 8'h00;
		apb(1'b1, `PMUX_OFF_PA_PU, 32'hff);
		settle(0);
		chk(pa_pu, 8'h02);
		apb(1'b1, `PMUX_OFF_CONV, 32'h02);
		settle(0);
		chk(pa_pu, 8'h00);
		chk(an_sel, 8'h02);
		// PWM0 owns PA4 as output; bit set copies the pin read
		apb(1'b1, `PMUX_OFF_MISC_A, 32'h4);
		settle(0);
		chk(pa_out[4], 1'b0);
		chk(pa_oe[4], 1'b1);
		apb(1'b1, `PMUX_OFF_PA_DIR, 32'h12);
		apb(1'b1, `PMUX_OFF_BITOP, 32'h08);
		settle(0);
		chk(pa_oe[4], 1'b0);
		chk(pa_out, 8'hed);
		// Common 0: slot 0 low, slots 1 to 3 mid bias, slot 4 high
		apb(1'b1, `PMUX_OFF_LCD, 32'h81);
		settle(0);
		chk({lcd, pb_oe[0], pb_out[0]}, 6'h02);
		settle(4);
		chk({lcd, pb_oe[0], pb_out[0]}, 6'h04);
		settle(12);
		chk({lcd, pb_oe[0], pb_out[0]}, 6'h03);
		// Unmapped address refused
		apb(1'b0, 12'h030, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
